// ---- hdl/nvmem_pkg.sv ----
// constants and carrier types for the two-wire memory slave
// assumes a single 20 MHz system clock domain
package nvmem_pkg;
  localparam int ADDR_W     = 9;
  localparam int MEM_DEPTH  = 512;
  localparam int BYTE_W     = 8;
  localparam int TYPE_HI    = 7;
  localparam int TYPE_LO    = 4;
  localparam int SEL_HI     = 3;
  localparam int SEL_LO     = 2;
  localparam int PAGE_BIT   = 1;
  localparam int RW_BIT     = 0;
  localparam int CNT_W      = 4;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam logic [8:0] ADDR_TOP   = 9'h01FF;
  localparam logic [8:0] ADDR_RST   = 9'h0000;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [3:0] CNT_RST    = 4'h0;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_s;

  typedef struct packed {
    logic       page;
    logic [7:0] lo;
  } addr_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_WORD, ST_WDATA, ST_ACK,
    ST_RDATA, ST_RACK, ST_RNEXT, ST_IGNORE
  } state_e;
endpackage

// ---- hdl/nvmem_slave.sv ----
// two-wire serial slave in front of a 512 x 8 nonvolatile array
// assumes scl/sda/select/protect arrive asynchronously to clk_in;
// sda is open drain: the bench resolves the wire from sda_oe_out
`timescale 1ns/10ps
`default_nettype none

module nvmem_slave
  import nvmem_pkg::*;
#(
  parameter int         DEPTH    = MEM_DEPTH,
  parameter logic [3:0] DEV_TYPE = 4'h5 // arbitrary value
)
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic [1:0] device_select_pins_in,
  input  wire logic       write_protect_in
);

  if (DEPTH != MEM_DEPTH)
  begin : g_depth_check
    $error("DEPTH must equal the nine-bit address space");
  end

  function automatic addr_s addr_inc(input addr_s a);
    addr_inc = addr_s'(9'(a + 9'h0001));
  endfunction

  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [1:0] sel);
    addr_match = (b[TYPE_HI:TYPE_LO] == DEV_TYPE) &&
                 (b[SEL_HI:SEL_LO] == sel);
  endfunction

  logic [7:0] mem [DEPTH];

  bus_s       s1_reg;
  bus_s       s2_reg;
  bus_s       s3_reg;
  logic [1:0] sel1_reg;
  logic [1:0] sel2_reg;
  logic       wp1_reg;
  logic       wp2_reg;
  state_e     state_reg;
  state_e     after_ack_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic       ack_reg;
  logic       oe_reg;
  addr_s      addr_reg;

  // scl/sda logic looks at the second and third stages; select and protect only at the second
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      s1_reg   <= '1;
      s2_reg   <= '1;
      s3_reg   <= '1;
      sel1_reg <= '0;
      sel2_reg <= '0;
      wp1_reg  <= 1'b0;
      wp2_reg  <= 1'b0;
    end
    else
    begin
      s1_reg   <= '{scl: scl_in, sda: sda_in};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      sel1_reg <= device_select_pins_in;
      sel2_reg <= sel1_reg;
      wp1_reg  <= write_protect_in;
      wp2_reg  <= wp1_reg;
    end
  end

  wire scl_rise  = s2_reg.scl & ~s3_reg.scl;
  wire scl_fall  = ~s2_reg.scl & s3_reg.scl;
  wire scl_high  = s2_reg.scl & s3_reg.scl;
  wire start_det = scl_high & s3_reg.sda & ~s2_reg.sda;
  wire stop_det  = scl_high & ~s3_reg.sda & s2_reg.sda;

  // protection is active high only; low or unused means writable
  wire protect = wp2_reg;

  wire receiving = (state_reg == ST_ADDR) || (state_reg == ST_WORD) ||
                   (state_reg == ST_WDATA);
  wire [7:0] rx_byte = {shift_reg[6:0], s2_reg.sda};
  wire rx_last = receiving && scl_rise && (cnt_reg == LAST_BIT);
  wire rx_shift = receiving && scl_rise && (cnt_reg < ACK_SLOT);
  wire slave_hit = addr_match(rx_byte, sel2_reg);
  wire wr_en = rx_last && (state_reg == ST_WDATA) && !protect;
  wire [7:0] rd_byte = mem[addr_reg];
  wire ack_slot_fall = receiving && scl_fall && (cnt_reg == ACK_SLOT);
  wire tx_done = (state_reg == ST_RDATA) && scl_fall &&
                 (cnt_reg == LAST_BIT);

  // array write lands before the ack bit is driven
  always_ff @(posedge clk_in)
  begin
    if (wr_en)
      mem[addr_reg] <= rx_byte;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      shift_reg <= BYTE_RST;
    else if (rx_shift)
      shift_reg <= rx_byte;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      cnt_reg <= CNT_RST;
    else if (start_det || stop_det)
      cnt_reg <= CNT_RST;
    else if (rx_shift)
      cnt_reg <= 4'(cnt_reg + 4'h1);
    else if ((state_reg == ST_ACK || state_reg == ST_RNEXT) && scl_fall)
      cnt_reg <= CNT_RST;
    else if (state_reg == ST_RDATA && scl_fall && !tx_done)
      cnt_reg <= 4'(cnt_reg + 4'h1);
  end

  // latch is not touched by start/stop, so it carries over
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      addr_reg <= addr_s'(ADDR_RST);
    else if (rx_last && state_reg == ST_ADDR && slave_hit)
      addr_reg.page <= rx_byte[PAGE_BIT];
    else if (rx_last && state_reg == ST_WORD)
      addr_reg.lo <= rx_byte;
    else if (wr_en || tx_done)
      addr_reg <= addr_inc(addr_reg);
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      tx_reg <= BYTE_RST;
    else if ((state_reg == ST_ACK && after_ack_reg == ST_RDATA &&
              scl_fall) || (state_reg == ST_RNEXT && scl_fall))
      tx_reg <= rd_byte;
    else if (state_reg == ST_RDATA && scl_fall)
      tx_reg <= {tx_reg[6:0], 1'b0};
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      state_reg     <= ST_IDLE;
      after_ack_reg <= ST_IDLE;
      ack_reg       <= 1'b0;
      oe_reg        <= 1'b0;
    end
    else if (start_det)
    begin
      // restart from any state, including the ninth read clock
      state_reg <= ST_ADDR;
      oe_reg    <= 1'b0;
    end
    else if (stop_det)
    begin
      // ready at once: no write busy window exists
      state_reg <= ST_IDLE;
      oe_reg    <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE, ST_IGNORE:
          oe_reg <= 1'b0;
        ST_ADDR:
          if (rx_last)
          begin
            ack_reg       <= slave_hit;
            after_ack_reg <= rx_byte[RW_BIT] ? ST_RDATA : ST_WORD;
            if (!slave_hit)
              state_reg <= ST_IGNORE;
          end
          else if (ack_slot_fall)
          begin
            oe_reg    <= ack_reg;
            state_reg <= ST_ACK;
          end
        ST_WORD:
          if (rx_last)
          begin
            ack_reg       <= 1'b1;
            after_ack_reg <= ST_WDATA;
          end
          else if (ack_slot_fall)
          begin
            oe_reg    <= ack_reg;
            state_reg <= ST_ACK;
          end
        ST_WDATA:
          if (rx_last)
            ack_reg <= !protect;
          else if (ack_slot_fall)
          begin
            oe_reg    <= ack_reg;
            state_reg <= ack_reg ? ST_ACK : ST_IGNORE;
          end
        ST_ACK:
          if (scl_fall)
          begin
            // first read bit goes out on this same falling edge
            state_reg <= after_ack_reg;
            oe_reg    <= (after_ack_reg == ST_RDATA) ? ~rd_byte[7] : 1'b0;
          end
        ST_RDATA:
          if (tx_done)
          begin
            oe_reg    <= 1'b0;
            state_reg <= ST_RACK;
          end
          else if (scl_fall)
            oe_reg <= ~tx_reg[6];
        ST_RACK:
          if (scl_rise)
            state_reg <= s2_reg.sda ? ST_IGNORE : ST_RNEXT;
        ST_RNEXT:
          if (scl_fall)
          begin
            state_reg <= ST_RDATA;
            oe_reg    <= ~rd_byte[7];
          end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_out    = 1'b0;
  assign sda_oe_out = oe_reg;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_prot_byte;
    rx_last && state_reg == ST_WDATA && protect;
  endsequence

  sequence s_free_byte;
    rx_last && state_reg == ST_WDATA && !protect;
  endsequence

  a_commit_data: assert property (
    s_free_byte |=> mem[$past(addr_reg)] == $past(rx_byte))
    else $error("data byte not committed on eighth bit");

  a_protect_store: assert property (
    s_prot_byte |-> !wr_en ##1 (!sda_oe_out)[*8])
    else $error("protected byte stored or acknowledged");

  a_protect_addr: assert property (
    s_prot_byte |=> addr_reg == $past(addr_reg))
    else $error("address moved on protected byte");

  a_addr_wrap: assert property (
    (wr_en || tx_done) && addr_reg == ADDR_TOP |=> addr_reg == ADDR_RST)
    else $error("address did not wrap to zero");

  a_data_ack: assert property (
    s_free_byte ##[1:16] (state_reg == ST_WDATA && scl_fall)
      |=> sda_oe_out && state_reg == ST_ACK)
    else $error("unprotected data byte not acknowledged");

  a_stop_release: assert property (
    stop_det |=> state_reg == ST_IDLE && !sda_oe_out)
    else $error("stop did not end operation");

  a_start_restart: assert property (
    start_det |=> state_reg == ST_ADDR && cnt_reg == CNT_RST && !sda_oe_out)
    else $error("start did not restart address decode");

  a_ignore_quiet: assert property (
    state_reg == ST_IGNORE |-> !sda_oe_out)
    else $error("line driven while ignoring");

  a_nack_end: assert property (
    state_reg == ST_RACK && scl_rise && s2_reg.sda && !stop_det && !start_det
      |=> state_reg == ST_IGNORE && !sda_oe_out)
    else $error("read continued after master nack");

  a_read_first: assert property (
    state_reg == ST_ACK && after_ack_reg == ST_RDATA && scl_fall &&
      !start_det && !stop_det
      |=> state_reg == ST_RDATA && tx_reg == $past(rd_byte) &&
          sda_oe_out == ~tx_reg[7])
    else $error("read data did not start after address ack");

  a_latch_kept: assert property (
    start_det || stop_det |=> addr_reg == $past(addr_reg))
    else $error("address latch lost on start or stop");

  a_word_load: assert property (
    rx_last && state_reg == ST_WORD && !start_det && !stop_det
      |=> addr_reg.lo == $past(rx_byte) && ack_reg)
    else $error("word address not loaded");

endmodule

`default_nettype wire

// ---- verification/nvmem_master_model.sv ----
// bus master model driving scl and sda of the memory slave
// assumes sda_wire_in is the resolved wire (pull-up, slave open drain)
`timescale 1ns/10ps
`default_nettype none
module nvmem_master_model
(
  input  wire logic clk_in,
  input  wire logic sda_wire_in,
  output logic      scl_out,
  output logic      sda_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // sda only moves while scl low; 5 low + 3 high clocks = 400 ns
  task automatic bit_io(input logic b, output logic r);
    scl_out <= 1'b0;
    tick(1);
    sda_out <= b;
    tick(4);
    scl_out <= 1'b1;
    tick(3);
    r = sda_wire_in;
  endtask
  // also serves as repeated start and as a mid-byte abort
  task automatic start();
    scl_out <= 1'b0;
    tick(1);
    sda_out <= 1'b1;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    scl_out <= 1'b0;
    tick(1);
    sda_out <= 1'b0;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b1;
    tick(4);
  endtask
  // eight bits then the acknowledge slot; 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] q, output logic s_ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(m_ack, r);
    s_ack = ~r;
  endtask
endmodule
`default_nettype wire

// ---- verification/nvmem_slave_bench.sv ----
// self-checking bench for the two-wire memory slave
// assumes nvmem_pkg, nvmem_slave and nvmem_master_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module nvmem_slave_bench;
  import nvmem_pkg::*;
  localparam logic [3:0] DEV_ID = 4'h5; // arbitrary value
  logic       clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       wp = 1'b0;
  logic [1:0] sel = 2'b10;
  logic       scl_w;
  logic       sda_m;
  logic       sda_o;
  logic       sda_oe;
  wire logic  sda_w;
  int         n_errors = 0;
  int         cmp_count = 0;
  logic       r;
  assign sda_w = sda_oe ? (sda_m & sda_o) : sda_m;
  always #25 clk_in = ~clk_in;
  nvmem_slave #(.DEPTH(MEM_DEPTH), .DEV_TYPE(DEV_ID)) uut (.clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl_w),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .device_select_pins_in(sel), .write_protect_in(wp));
  nvmem_master_model m (.clk_in(clk_in), .sda_wire_in(sda_w), .scl_out(scl_w), .sda_out(sda_m));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d, compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [7:0] ab(input logic pg, input logic rw);
    return {DEV_ID, sel, pg, rw};
  endfunction
  // start, slave address, check its acknowledge
  task automatic sa(input logic [7:0] b, input logic e);
    logic [7:0] q;
    logic       a;
    m.start();
    m.xfer(b, 1'b1, q, a);
    chk({7'h00, a}, {7'h00, e});
  endtask
  task automatic wb(input logic [7:0] d, input logic e);
    logic [7:0] q;
    logic       a;
    m.xfer(d, 1'b1, q, a);
    chk({7'h00, a}, {7'h00, e});
  endtask
  // nack = 1 ends the read
  task automatic rb(input logic [7:0] e, input logic nack);
    logic [7:0] q;
    logic       a;
    m.xfer(8'hFF, nack, q, a);
    chk(q, e);
  endtask
  // eight read bits only; the caller ends inside the ninth clock
  task automatic rb8(input logic [7:0] e);
    logic [7:0] q;
    logic       b;
    for (int i = 7; i >= 0; i--)
    begin
      m.bit_io(1'b1, b);
      q[i] = b;
    end
    chk(q, e);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    sa(ab(1'b1, 1'b0), 1'b1);
    wb(8'hFE, 1'b1);
    wb(8'hA0, 1'b1);
    wb(8'hA1, 1'b1);
    wb(8'hA2, 1'b1);
    wb(8'hA3, 1'b1);
    m.stop();
    sa(ab(1'b1, 1'b0), 1'b1);
    wb(8'hFE, 1'b1);
    sa(ab(1'b1, 1'b1), 1'b1);
    rb(8'hA0, 1'b0);
    rb(8'hA1, 1'b0);
    rb(8'hA2, 1'b1);
    m.stop();
    sa(ab(1'b0, 1'b1), 1'b1);
    rb(8'hA3, 1'b1);
    m.stop();
    sa(ab(1'b0, 1'b0), 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h3C, 1'b1);
    m.stop();
    wp <= 1'b1;
    sa(ab(1'b0, 1'b0), 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h55, 1'b0);
    m.stop();
    wp <= 1'b0;
    sa(ab(1'b0, 1'b1), 1'b1);
    rb(8'h3C, 1'b1);
    m.stop();
    sa(ab(1'b0, 1'b0), 1'b1);
    wb(8'h20, 1'b1);
    wb(8'h11, 1'b1);
    m.stop();
    sa(ab(1'b0, 1'b0), 1'b1);
    wb(8'h20, 1'b1);
    // five bits of a new byte, then a repeated start
    repeat (5) m.bit_io(1'b0, r);
    sa(ab(1'b0, 1'b1), 1'b1);
    rb(8'h11, 1'b1);
    m.stop();
    // three known bytes, then two reads cut off inside the ninth clock and one full read
    sa(ab(1'b0, 1'b0), 1'b1);
    wb(8'h30, 1'b1);
    wb(8'h5A, 1'b1);
    wb(8'h6B, 1'b1);
    wb(8'h7C, 1'b1);
    m.stop();
    sa(ab(1'b0, 1'b0), 1'b1);
    wb(8'h30, 1'b1);
    sa(ab(1'b0, 1'b1), 1'b1);
    rb8(8'h5A);
    m.stop();
    sa(ab(1'b0, 1'b1), 1'b1);
    rb8(8'h6B);
    sa(ab(1'b0, 1'b1), 1'b1);
    rb(8'h7C, 1'b1);
    m.stop();
    sa({DEV_ID, ~sel, 2'b01}, 1'b0);
    m.stop();
    sa({~DEV_ID, sel, 2'b01}, 1'b0);
    m.stop();
    conclude();
  end
endmodule
`default_nettype wire
